/* design/mgsr_defs.vh */
`ifndef MGSR_DEFS_VH
`define MGSR_DEFS_VH

// register indices; byte address is four times the index
`define MGSR_IDX_X_HIGH 4'h3
`define MGSR_IDX_X_LOW 4'h4
`define MGSR_IDX_Y_HIGH 4'h5
`define MGSR_IDX_Y_LOW 4'h6
`define MGSR_IDX_Z_HIGH 4'h7
`define MGSR_IDX_Z_LOW 4'h8
`define MGSR_IDX_STATUS 4'h9
`define MGSR_IDX_IDENT_A 4'hA
`define MGSR_IDX_IDENT_B 4'hB
`define MGSR_IDX_IDENT_C 4'hC

// status field positions
`define MGSR_SR_READY 0
`define MGSR_SR_LOCK 1
`define MGSR_SR_REGEN 2

// result code forced on overflow, -4096
`define MGSR_OVF_MARKER 16'hF000
`define MGSR_RESULT_MIN 16'hF800
`define MGSR_RESULT_MAX 16'h07FF

// op_select_hi/op_select_lo encodings
`define MGSR_MODE_CONT 2'h0
`define MGSR_MODE_SINGLE 2'h1
`define MGSR_MODE_SLEEP 2'h3

// timing
`define MGSR_CLK_HZ 32'd20000000
`define MGSR_CHZ_PER_HZ 32'd100
`define MGSR_RDY_LOW_NS 32'd5000
`define MGSR_RDY_LOW_CYC ((`MGSR_RDY_LOW_NS * (`MGSR_CLK_HZ / 32'd1000000) + 32'd999) / 32'd1000)

// output_rate in hundredths of a hertz
`define MGSR_RATE0_CHZ 32'd75
`define MGSR_RATE1_CHZ 32'd150
`define MGSR_RATE2_CHZ 32'd300
`define MGSR_RATE3_CHZ 32'd750
`define MGSR_RATE4_CHZ 32'd1500
`define MGSR_RATE5_CHZ 32'd3000
`define MGSR_RATE6_CHZ 32'd7500

// bus responses
`define MGSR_RESP_OKAY 2'h0
`define MGSR_RESP_SLVERR 2'h2

`endif

/* design/mgsr_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "mgsr_defs.vh"

// Functional notes
// - X result in two 8-bit registers, high byte at lower address.
// - results are signed 16-bit two's complement within the allowed span.
// - overflow or bias math overflow loads the channel with -4096.
// - overflow marker stays only until the next valid measurement replaces it.
// - after any result read, no new results until all six are read, the mode or config changes, or reset.
// - ready bit and pin stay set until a new result set lands, the regulator turns off, or a single-mode full read.
// - status is read-only: ready bit 0, lock bit 1, regulator bit 2.
// - status bits seven to three read zero.
// - regulator bit follows the internal regulator enable.
// - lock set when some but not all six results were read.
// - lock released on all read, mode change, reset, or config change.
// - ready set once a full result set is written.
// - ready cleared on result write start, in off mode, after all six are read in single mode.
// - ready stays low at least five microseconds once cleared.
// - data-ready pin mirrors the ready status bit.
// - three read-only identification registers with fixed values.
// - Y pair follows X pair, high byte first.
// - Z pair sits just below the status register, high byte first.
// - single mode takes one measurement, sets ready, returns to sleep.
// - continuous mode: first set after two periods, then one per period.
module mgsr_top #(
	parameter [31:0] PERIOD_0 = (`MGSR_CLK_HZ * `MGSR_CHZ_PER_HZ) / `MGSR_RATE0_CHZ,
	parameter [31:0] PERIOD_1 = (`MGSR_CLK_HZ * `MGSR_CHZ_PER_HZ) / `MGSR_RATE1_CHZ,
	parameter [31:0] PERIOD_2 = (`MGSR_CLK_HZ * `MGSR_CHZ_PER_HZ) / `MGSR_RATE2_CHZ,
	parameter [31:0] PERIOD_3 = (`MGSR_CLK_HZ * `MGSR_CHZ_PER_HZ) / `MGSR_RATE3_CHZ,
	parameter [31:0] PERIOD_4 = (`MGSR_CLK_HZ * `MGSR_CHZ_PER_HZ) / `MGSR_RATE4_CHZ,
	parameter [31:0] PERIOD_5 = (`MGSR_CLK_HZ * `MGSR_CHZ_PER_HZ) / `MGSR_RATE5_CHZ,
	parameter [31:0] PERIOD_6 = (`MGSR_CLK_HZ * `MGSR_CHZ_PER_HZ) / `MGSR_RATE6_CHZ,
	// identification values are arbitrary
	parameter [7:0] IDENT_A = 8'h5A,
	parameter [7:0] IDENT_B = 8'h3C,
	parameter [7:0] IDENT_C = 8'h6E
) (
	input wire CLK,
	input wire RST,
	input wire [7:0] S_AXI_AWADDR,
	input wire [2:0] S_AXI_AWPROT,
	input wire S_AXI_AWVALID,
	output wire S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output wire S_AXI_WREADY,
	output wire [1:0] S_AXI_BRESP,
	output wire S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [7:0] S_AXI_ARADDR,
	input wire [2:0] S_AXI_ARPROT,
	input wire S_AXI_ARVALID,
	output wire S_AXI_ARREADY,
	output wire [31:0] S_AXI_RDATA,
	output wire [1:0] S_AXI_RRESP,
	output wire S_AXI_RVALID,
	input wire S_AXI_RREADY,
	input wire OP_SELECT_HI,
	input wire OP_SELECT_LO,
	input wire [2:0] OUTPUT_RATE,
	input wire CFG_WRITE,
	input wire REG_ENABLED,
	output wire SAMPLE_REQ,
	input wire MEAS_VALID,
	input wire [15:0] MEAS_X,
	input wire [15:0] MEAS_Y,
	input wire [15:0] MEAS_Z,
	input wire MEAS_X_OVF,
	input wire MEAS_Y_OVF,
	input wire MEAS_Z_OVF,
	output wire SINGLE_DONE,
	output wire DATA_READY_PIN
);

	wire [1:0] op_select;
	wire mode_change;
	wire restart;
	wire lock;
	wire all_read;
	wire update;
	wire ar_hit;
	wire [3:0] ar_idx;
	wire [5:0] rd_hit;
	wire aw_take;
	wire w_take;
	wire aw_have;
	wire w_have;
	wire wr_done;
	reg [1:0] op_select_ff;
	reg [15:0] x_res_ff;
	reg [15:0] y_res_ff;
	reg [15:0] z_res_ff;
	reg [5:0] read_flags_ff;
	reg [5:0] nxt_read_flags;
	reg rdy_ff;
	reg nxt_rdy;
	reg rdy_pend_ff;
	reg nxt_rdy_pend;
	reg [31:0] low_cnt_ff;
	reg [31:0] nxt_low_cnt;
	reg [32:0] pace_cnt_ff;
	reg [32:0] nxt_pace_cnt;
	reg single_arm_ff;
	reg single_wait_ff;
	reg sample_req_ff;
	reg single_done_ff;
	reg [31:0] period;
	reg aw_got_ff;
	reg w_got_ff;
	reg aw_bad_ff;
	reg bvalid_ff;
	reg [1:0] bresp_ff;
	reg rvalid_ff;
	reg [1:0] rresp_ff;
	reg [31:0] rdata_ff;
	reg [7:0] rd_byte;
	reg rd_ok;

	assign op_select = {OP_SELECT_HI, OP_SELECT_LO};
	assign mode_change = (op_select != op_select_ff);
	assign restart = mode_change | CFG_WRITE;

	// read tracking and lock
	assign lock = (|read_flags_ff) & ~(&read_flags_ff);
	assign all_read = &(read_flags_ff | rd_hit);
	assign update = MEAS_VALID & ~lock;

	always @* begin
		nxt_read_flags = read_flags_ff | rd_hit;
		if (all_read | restart) begin
			nxt_read_flags = 6'h00;
		end
	end

	always @(posedge CLK) begin
		if (RST) begin
			read_flags_ff <= 6'h00;
			op_select_ff <= `MGSR_MODE_SLEEP;
		end else begin
			read_flags_ff <= nxt_read_flags;
			op_select_ff <= op_select;
		end
	end

	// result holding; a locked set drops the incoming measurement
	always @(posedge CLK) begin
		if (RST) begin
			x_res_ff <= 16'h0000;
			y_res_ff <= 16'h0000;
			z_res_ff <= 16'h0000;
		end else if (update) begin
			// two's complement words stored as delivered
			// marker replaced by the next good sample
			x_res_ff <= MEAS_X_OVF ? `MGSR_OVF_MARKER : MEAS_X;
			y_res_ff <= MEAS_Y_OVF ? `MGSR_OVF_MARKER : MEAS_Y;
			z_res_ff <= MEAS_Z_OVF ? `MGSR_OVF_MARKER : MEAS_Z;
		end
	end

	// ready bit with minimum low time
	always @* begin
		nxt_rdy = rdy_ff;
		nxt_rdy_pend = rdy_pend_ff;
		nxt_low_cnt = (low_cnt_ff != 32'd0) ? low_cnt_ff - 32'd1 : 32'd0;
		if (!REG_ENABLED) begin
			nxt_rdy = 1'b0;
			nxt_rdy_pend = 1'b0;
			nxt_low_cnt = `MGSR_RDY_LOW_CYC;
		end else if (update) begin
			nxt_rdy = 1'b0;
			nxt_rdy_pend = 1'b1;
			nxt_low_cnt = `MGSR_RDY_LOW_CYC;
		end else if (rdy_pend_ff && low_cnt_ff == 32'd0) begin
			nxt_rdy = 1'b1;
			nxt_rdy_pend = 1'b0;
		end else if (rdy_ff && all_read && (|rd_hit) &&
			op_select == `MGSR_MODE_SINGLE) begin
			nxt_rdy = 1'b0;
			nxt_low_cnt = `MGSR_RDY_LOW_CYC;
		end
	end

	always @(posedge CLK) begin
		if (RST) begin
			rdy_ff <= 1'b0;
			rdy_pend_ff <= 1'b0;
			low_cnt_ff <= 32'd0;
		end else begin
			rdy_ff <= nxt_rdy;
			rdy_pend_ff <= nxt_rdy_pend;
			low_cnt_ff <= nxt_low_cnt;
		end
	end

	assign DATA_READY_PIN = rdy_ff;

	// measurement pacing
	always @* begin
		case (OUTPUT_RATE)
			3'h0: period = PERIOD_0;
			3'h1: period = PERIOD_1;
			3'h2: period = PERIOD_2;
			3'h3: period = PERIOD_3;
			3'h4: period = PERIOD_4;
			3'h5: period = PERIOD_5;
			3'h6: period = PERIOD_6;
			default: period = 32'd0;
		endcase
	end

	always @* begin
		nxt_pace_cnt = pace_cnt_ff;
		if (restart) begin
			nxt_pace_cnt = {period, 1'b0};
		end else if (op_select == `MGSR_MODE_CONT && period != 32'd0) begin
			if (pace_cnt_ff <= 33'd1) begin
				nxt_pace_cnt = {1'b0, period};
			end else begin
				nxt_pace_cnt = pace_cnt_ff - 33'd1;
			end
		end
	end

	always @(posedge CLK) begin
		if (RST) begin
			pace_cnt_ff <= 33'd0;
			single_arm_ff <= 1'b0;
			single_wait_ff <= 1'b0;
			sample_req_ff <= 1'b0;
			single_done_ff <= 1'b0;
		end else begin
			pace_cnt_ff <= nxt_pace_cnt;
			sample_req_ff <= 1'b0;
			single_done_ff <= 1'b0;
			if (restart) begin
				single_arm_ff <= (op_select == `MGSR_MODE_SINGLE);
				single_wait_ff <= 1'b0;
			end else if (op_select == `MGSR_MODE_CONT) begin
				sample_req_ff <= (period != 32'd0) &&
					(pace_cnt_ff == 33'd1);
			end else if (single_arm_ff) begin
				sample_req_ff <= 1'b1;
				single_arm_ff <= 1'b0;
				single_wait_ff <= 1'b1;
			end else if (single_wait_ff && MEAS_VALID) begin
				single_done_ff <= 1'b1;
				single_wait_ff <= 1'b0;
			end
		end
	end

	assign SAMPLE_REQ = sample_req_ff;
	assign SINGLE_DONE = single_done_ff;

	// bus slave: writes are accepted and discarded
	assign S_AXI_AWREADY = ~aw_got_ff & ~bvalid_ff;
	assign S_AXI_WREADY = ~w_got_ff & ~bvalid_ff;
	assign aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
	assign w_take = S_AXI_WVALID & S_AXI_WREADY;
	assign aw_have = aw_got_ff | aw_take;
	assign w_have = w_got_ff | w_take;
	assign wr_done = aw_have & w_have & ~bvalid_ff;

	always @(posedge CLK) begin
		if (RST) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			aw_bad_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `MGSR_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_bad_ff <= (S_AXI_AWADDR[1:0] != 2'h0) ||
					(S_AXI_AWADDR[5:2] < `MGSR_IDX_X_HIGH) ||
					(S_AXI_AWADDR[5:2] > `MGSR_IDX_IDENT_C) ||
					(S_AXI_AWADDR[7:6] != 2'h0);
			end
			if (wr_done) begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				if (aw_take) begin
					bresp_ff <= ((S_AXI_AWADDR[1:0] != 2'h0) ||
						(S_AXI_AWADDR[5:2] < `MGSR_IDX_X_HIGH) ||
						(S_AXI_AWADDR[5:2] > `MGSR_IDX_IDENT_C) ||
						(S_AXI_AWADDR[7:6] != 2'h0)) ?
						`MGSR_RESP_SLVERR : `MGSR_RESP_OKAY;
				end else begin
					bresp_ff <= aw_bad_ff ? `MGSR_RESP_SLVERR :
						`MGSR_RESP_OKAY;
				end
			end else begin
				if (aw_take) begin
					aw_got_ff <= 1'b1;
				end
				if (w_take) begin
					w_got_ff <= 1'b1;
				end
				if (bvalid_ff && S_AXI_BREADY) begin
					bvalid_ff <= 1'b0;
				end
			end
		end
	end

	assign S_AXI_BVALID = bvalid_ff;
	assign S_AXI_BRESP = bresp_ff;

	// bus slave: reads
	assign S_AXI_ARREADY = ~rvalid_ff;
	assign ar_hit = S_AXI_ARVALID & ~rvalid_ff;
	assign ar_idx = S_AXI_ARADDR[5:2];

	always @* begin
		rd_ok = (S_AXI_ARADDR[1:0] == 2'h0) && (S_AXI_ARADDR[7:6] == 2'h0);
		rd_byte = 8'h00;
		case (ar_idx)
			`MGSR_IDX_X_HIGH: rd_byte = x_res_ff[15:8];
			`MGSR_IDX_X_LOW: rd_byte = x_res_ff[7:0];
			`MGSR_IDX_Y_HIGH: rd_byte = y_res_ff[15:8];
			`MGSR_IDX_Y_LOW: rd_byte = y_res_ff[7:0];
			`MGSR_IDX_Z_HIGH: rd_byte = z_res_ff[15:8];
			`MGSR_IDX_Z_LOW: rd_byte = z_res_ff[7:0];
			`MGSR_IDX_STATUS: begin
				rd_byte = 8'h00;
				rd_byte[`MGSR_SR_READY] = rdy_ff;
				rd_byte[`MGSR_SR_LOCK] = lock;
				rd_byte[`MGSR_SR_REGEN] = REG_ENABLED;
			end
			`MGSR_IDX_IDENT_A: rd_byte = IDENT_A;
			`MGSR_IDX_IDENT_B: rd_byte = IDENT_B;
			`MGSR_IDX_IDENT_C: rd_byte = IDENT_C;
			default: rd_ok = 1'b0;
		endcase
	end

	// one flag per result register, index 3 to 8
	assign rd_hit = (ar_hit && rd_ok &&
		ar_idx >= `MGSR_IDX_X_HIGH && ar_idx <= `MGSR_IDX_Z_LOW) ?
		(6'h01 << (ar_idx - `MGSR_IDX_X_HIGH)) : 6'h00;

	always @(posedge CLK) begin
		if (RST) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= `MGSR_RESP_OKAY;
			rdata_ff <= 32'h00000000;
		end else if (ar_hit) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= rd_ok ? `MGSR_RESP_OKAY : `MGSR_RESP_SLVERR;
			rdata_ff <= rd_ok ? {24'h000000, rd_byte} : 32'h00000000;
		end else if (rvalid_ff && S_AXI_RREADY) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign S_AXI_RVALID = rvalid_ff;
	assign S_AXI_RRESP = rresp_ff;
	assign S_AXI_RDATA = rdata_ff;

endmodule // mgsr_top

`default_nettype wire

/* dv/mgsr_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mgsr_core_model #(
	parameter int DELAY = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sample_req,
	input wire logic [15:0] vx,
	input wire logic [15:0] vy,
	input wire logic [15:0] vz,
	input wire logic [2:0] ovf,
	output logic meas_valid,
	output wire logic [15:0] meas_x,
	output wire logic [15:0] meas_y,
	output wire logic [15:0] meas_z,
	output wire logic [2:0] meas_ovf
);
	int cnt_ff;
	// answer DELAY cycles after a request; data scrambled outside the pulse
	always @(posedge clk) begin
		if (rst) begin
			cnt_ff <= 0;
			meas_valid <= 1'b0;
		end else begin
			meas_valid <= (cnt_ff == 1);
			if (sample_req) begin
				cnt_ff <= DELAY;
			end else if (cnt_ff != 0) begin
				cnt_ff <= cnt_ff - 1;
			end
		end
	end
	assign meas_x = meas_valid ? vx : ~vx;
	assign meas_y = meas_valid ? vy : ~vy;
	assign meas_z = meas_valid ? vz : ~vz;
	assign meas_ovf = meas_valid ? ovf : ~ovf;
endmodule // mgsr_core_model
`default_nettype wire

/* dv/mgsr_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module mgsr_checker #(
	parameter logic [7:0] IDENT_A = 8'h00,
	parameter logic [7:0] IDENT_B = 8'h00,
	parameter logic [7:0] IDENT_C = 8'h00
) (
	input wire CLK,
	input wire RST,
	input wire [7:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	input wire S_AXI_ARREADY,
	input wire [31:0] S_AXI_RDATA,
	input wire [1:0] S_AXI_RRESP,
	input wire S_AXI_RVALID,
	input wire REG_ENABLED,
	input wire MEAS_VALID,
	input wire SINGLE_DONE,
	input wire DATA_READY_PIN
);
	logic [7:0] ra_ff, lo_ff;
	logic ren_ff, pin_ff;
	wire sr = S_AXI_RVALID && ra_ff == 8'h24;
	always @(posedge CLK) begin
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			ra_ff <= S_AXI_ARADDR;
			ren_ff <= REG_ENABLED;
			pin_ff <= DATA_READY_PIN;
		end
		if (RST || DATA_READY_PIN) begin
			lo_ff <= 8'h00;
		end else if (lo_ff != 8'hFF) begin
			lo_ff <= lo_ff + 8'h01;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	AST_RDY_LOW: assert property ($rose(DATA_READY_PIN) |-> lo_ff >= 8'd100)
		else $error("ready rose too soon");
	AST_OFF: assert property (!REG_ENABLED |-> ##[1:2] !DATA_READY_PIN)
		else $error("ready kept in off mode");
	AST_SINGLE: assert property (SINGLE_DONE |-> $past(MEAS_VALID))
		else $error("single done without sample");
	AST_R_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	AST_UPPER: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
		else $error("upper read bits set");
	AST_SR_ZERO: assert property (sr |-> S_AXI_RDATA[7:3] == 5'h00)
		else $error("status high bits set");
	AST_SR_REGEN: assert property (sr |-> S_AXI_RDATA[2] == ren_ff)
		else $error("regulator bit wrong");
	AST_SR_PIN: assert property (sr |-> S_AXI_RDATA[0] == pin_ff)
		else $error("pin differs from ready bit");
	AST_IDENT: assert property (S_AXI_RVALID && ra_ff == 8'h28 |->
		S_AXI_RDATA[7:0] == IDENT_A) else $error("ident wrong");
	AST_IDENT_B: assert property (S_AXI_RVALID && ra_ff == 8'h2C |->
		S_AXI_RDATA[7:0] == IDENT_B) else $error("second ident wrong");
	AST_IDENT_C: assert property (S_AXI_RVALID && ra_ff == 8'h30 |->
		S_AXI_RDATA[7:0] == IDENT_C) else $error("third ident wrong");
	AST_BAD: assert property (S_AXI_RVALID && (ra_ff[1:0] != 2'h0 ||
		ra_ff < 8'h0C || ra_ff > 8'h30) |-> S_AXI_RRESP == 2'h2)
		else $error("unmapped read not refused");
	COV_RDY: cover property ($rose(DATA_READY_PIN));
	COV_SINGLE: cover property (SINGLE_DONE);
	COV_BAD: cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);
endmodule // mgsr_checker
bind mgsr_top mgsr_checker #(.IDENT_A(IDENT_A), .IDENT_B(IDENT_B),
	.IDENT_C(IDENT_C)) i_mgsr_checker (.CLK(CLK), .RST(RST),
	.S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
	.REG_ENABLED(REG_ENABLED), .MEAS_VALID(MEAS_VALID),
	.SINGLE_DONE(SINGLE_DONE), .DATA_READY_PIN(DATA_READY_PIN));
`default_nettype wire

/* dv/tb_magnetometer_output_status_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_magnetometer_output_status_regs;
	localparam int P = 200;
	// identification values are arbitrary
	localparam logic [7:0] ID_A = 8'hA1, ID_B = 8'hB2, ID_C = 8'hC3;
	logic clk = 1'b0, rst = 1'b1, cfg = 1'b0, ren = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic awready, wready, bvalid, arready, rvalid, sreq, sdone, pin, mv;
	logic [1:0] bresp, rresp, op = 2'h0;
	logic [15:0] vx = 16'h07FF, vy = 16'hF800, vz = 16'h0123, mx, my, mz;
	logic [2:0] ovf = 3'h0, mo;
	int fail_count = 0, check_count = 0, cyc = 0;
	always #25 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	mgsr_top #(.PERIOD_0(P), .IDENT_A(ID_A), .IDENT_B(ID_B), .IDENT_C(ID_C))
	i_mgsr_top (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
	.S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
	.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
	.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
	.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
	.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
	.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
	.OP_SELECT_HI(op[1]), .OP_SELECT_LO(op[0]), .OUTPUT_RATE(3'h0),
	.CFG_WRITE(cfg), .REG_ENABLED(ren), .SAMPLE_REQ(sreq), .MEAS_VALID(mv),
	.MEAS_X(mx), .MEAS_Y(my), .MEAS_Z(mz), .MEAS_X_OVF(mo[0]),
	.MEAS_Y_OVF(mo[1]), .MEAS_Z_OVF(mo[2]), .SINGLE_DONE(sdone),
	.DATA_READY_PIN(pin));
	mgsr_core_model #(.DELAY(3)) i_mgsr_core_model (.clk(clk), .rst(rst),
	.sample_req(sreq), .vx(vx), .vy(vy), .vz(vz), .ovf(ovf),
	.meas_valid(mv), .meas_x(mx), .meas_y(my), .meas_z(mz), .meas_ovf(mo));
	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	// handshakes are judged on the values sampled at the rising edge
	task automatic rd(input logic [7:0] a, output logic [33:0] d);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		d = {rresp, rdata};
		rready <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [33:0] d;
		rd(a, d);
		chk(d, {26'h0, e});
	endtask
	task automatic wr(input logic [7:0] a, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= 32'hFFFFFFFF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge clk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	// result bytes from index k up to index 5, high byte at the lower address
	task automatic rset(input int k, input logic [47:0] ex);
		for (int i = k; i < 6; i++) rc(8'h0C + 8'(4 * i), ex[47 - 8 * i -: 8]);
	endtask
	task automatic wreq;
		@(negedge clk);
		while (!sreq) @(negedge clk);
	endtask
	task automatic wset;
		wreq;
		repeat (5) @(negedge clk);
		while (!pin) @(negedge clk);
	endtask
	task wrap_up;
		if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		wrap_up;
	end
	initial begin
		logic [33:0] d;
		logic [1:0] r;
		int c0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		c0 = cyc;
		rc(8'h28, ID_A);
		rc(8'h2C, ID_B);
		rc(8'h30, ID_C);
		rc(8'h24, 8'h04);
		wr(8'h28, r);
		chk({32'h0, r}, 34'h0);
		rc(8'h28, ID_A);
		wr(8'h34, r);
		chk({32'h0, r}, 34'h2);
		rd(8'h34, d);
		chk(d, {2'h2, 32'h0});
		wreq;
		chk({33'h0, cyc - c0 >= 2 * P - 3 && cyc - c0 <= 2 * P + 3}, 34'h1);
		while (!pin) @(negedge clk);
		c0 = cyc;
		@(posedge clk) ovf <= 3'h1;
		rc(8'h24, 8'h05);
		rset(0, {16'h07FF, 16'hF800, 16'h0123});
		wset;
		chk({33'h0, cyc - c0 == P}, 34'h1);
		rc(8'h0C, 8'hF0);
		rc(8'h24, 8'h07);
		@(posedge clk);
		ovf <= 3'h0;
		vx <= 16'h0100;
		wreq;
		wreq;
		repeat (10) @(negedge clk);
		chk({33'h0, pin}, 34'h1);
		rset(1, {16'hF000, 16'hF800, 16'h0123});
		rc(8'h24, 8'h05);
		wset;
		rset(0, {16'h0100, 16'hF800, 16'h0123});
		rc(8'h0C, 8'h01);
		@(posedge clk) cfg <= 1'b1;
		@(posedge clk) cfg <= 1'b0;
		rc(8'h24, 8'h05);
		@(posedge clk) ren <= 1'b0;
		repeat (3) @(posedge clk);
		rc(8'h24, 8'h00);
		@(posedge clk);
		ren <= 1'b1;
		op <= 2'h1;
		@(negedge clk);
		while (!sdone) @(negedge clk);
		while (!pin) @(negedge clk);
		rc(8'h24, 8'h05);
		rset(0, {16'h0100, 16'hF800, 16'h0123});
		rc(8'h24, 8'h04);
		wrap_up;
	end
endmodule // tb_magnetometer_output_status_regs
`default_nettype wire
